/* File: include/hba_regs.vh */
// register map, field positions, reset values and timing for hba
// Behaviour
// R1 - latched alarm holds until a latch clear
// R2 - power cycle, function key, event clear latch
// R3 - entering setup levels clears held latches
// R4 - alarm when heating and current below threshold
// R5 - burnout judged against heating output only
// R6 - skip short heating on intervals
// R7 - burnout alarm defaults to aux output 1
// R8 - burnout separate; integrated alarm ORs everything
// R9 - burnout enable setting, resets to on
// R10 - burnout latch setting, resets to off
// R11 - shared hysteresis 0.1 to 50.0 A
// R12 - two thresholds 0.0 to 50.0 A
// R13 - readable current per channel, 0 to 55 A
// R14 - alarm never touches the control output
// R15 - heater supply on before controller supply
// R16 - standby sequence withholds alarm until re-entry
// R17 - clear only above threshold plus hysteresis; the code clears at or above it
`ifndef HBA_REGS_VH
`define HBA_REGS_VH

// ==========================================================
// bus geometry
`define HBA_AW 8
`define HBA_DW 16
`define HBA_CW 10

// ==========================================================
// register offsets
`define HBA_OFF_CTRL 8'h00
`define HBA_OFF_HYST 8'h01
`define HBA_OFF_THR1 8'h02
`define HBA_OFF_THR2 8'h03
`define HBA_OFF_CUR1 8'h04
`define HBA_OFF_CUR2 8'h05
`define HBA_OFF_ASGN 8'h06
`define HBA_OFF_STAT 8'h07
`define HBA_OFF_CMD 8'h08
`define HBA_OFF_GCFG 8'h09

// ==========================================================
// control fields
`define HBA_CTRL_EN 0
`define HBA_CTRL_LATCH 1
`define HBA_CTRL_FAST 2
`define HBA_CMD_CLEAR 0
`define HBA_CMD_RESTART 1

// ==========================================================
// reset values (currents in 0.1 A steps)
`define HBA_CTRL_RST 3'h1
`define HBA_HYST_RST 10'h001
`define HBA_THR_RST 10'h000
`define HBA_ASGN_RST 8'h01
`define HBA_GCFG_RST 8'h00

// ==========================================================
// setting limits
`define HBA_HYST_MIN 10'h001
`define HBA_SET_MAX 10'h1f4
`define HBA_CUR_MAX 10'h226

// ==========================================================
// aux output selections
`define HBA_SEL_OFF 2'h0
`define HBA_SEL_BURN 2'h1
`define HBA_SEL_HEAT 2'h2
`define HBA_SEL_INTG 2'h3

// ==========================================================
// setting levels
`define HBA_LVL_OPER 3'h0
`define HBA_LVL_ADJ 3'h1
`define HBA_LVL_INIT 3'h2
`define HBA_LVL_COMM 3'h3
`define HBA_LVL_ADV 3'h4
`define HBA_LVL_CAL 3'h5

// ==========================================================
// timing
`define HBA_CLK_MHZ 250
`define HBA_SKIP_LONG_MS 100
`define HBA_SKIP_SHORT_MS 30

`endif

/* File: rtl/hba_ch_detect.v */
// one current channel compared against its burnout threshold
`timescale 1ns/1ps
module hba_ch_detect (
  // clock and reset
  input wire clk,
  input wire reset,
  // qualifiers
  input wire enable,
  input wire eval,
  // current and settings, 0.1 A steps
  input wire [9:0] current,
  input wire [9:0] thr,
  input wire [9:0] hyst,
  // result
  output reg alarm_ff
);

  // release point, one bit wider so it cannot wrap
  wire [10:0] release_lvl;
  reg nxt_alarm;

  assign release_lvl = {1'b0, thr} + {1'b0, hyst};

  // ==========================================================
  // set below threshold, release at or above threshold plus hysteresis
  always @* begin
    nxt_alarm = alarm_ff;
    if (!enable) begin
      nxt_alarm = 1'b0; // see R9
    end else if (eval) begin
      if (current < thr) begin
        nxt_alarm = 1'b1; // see R4
      end else if ({1'b0, current} >= release_lvl) begin
        nxt_alarm = 1'b0; // see R17
      end
    end
  end

  // result state
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= nxt_alarm;
    end
  end

endmodule

/* File: rtl/hba_alarm_latch.v */
// alarm qualifier: standby sequence and latch
`timescale 1ns/1ps
module hba_alarm_latch (
  // clock and reset
  input wire clk,
  input wire reset,
  // raw condition and settings
  input wire raw,
  input wire latch_en,
  input wire standby_en,
  // one-cycle controls
  input wire restart,
  input wire clear,
  // qualified alarm
  output reg alarm_ff
);

  reg wait_ff; // standby armed, alarm withheld
  reg held_ff; // latched alarm
  wire live;

  // withheld until the condition has gone away once
  assign live = raw & ~(standby_en & wait_ff); // see R16

  // ==========================================================
  // standby: armed at reset and on restart, cancelled by leaving
  // the alarm range; once the alarm has shown it stays cancelled
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_ff <= 1'b1;
    end else if (restart) begin
      wait_ff <= 1'b1; // see R16
    end else if (!raw) begin
      wait_ff <= 1'b0; // see R16
    end
  end

  // latch: the set wins over a simultaneous clear
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      held_ff <= 1'b0; // see R2
    end else if (live & latch_en) begin
      held_ff <= 1'b1; // see R1
    end else if (clear | ~latch_en) begin
      held_ff <= 1'b0; // see R2
    end
  end

  // output flop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= live | (held_ff & latch_en); // see R1
    end
  end

endmodule

/* File: rtl/hba_top.v */
// heater burnout detection, alarm latching and aux output routing
`timescale 1ns/1ps
`include "hba_regs.vh"
module hba_top #(
  // heating on times that are ignored, in clock cycles
  parameter [31:0] SKIP_LONG_CYC =
    `HBA_SKIP_LONG_MS * 1000 * `HBA_CLK_MHZ,
  parameter [31:0] SKIP_SHORT_CYC =
    `HBA_SKIP_SHORT_MS * 1000 * `HBA_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_ff,
  // heating control output, observed only
  input wire heat_out,
  // current transformer readings, 0.1 A steps
  input wire [9:0] ct1_current,
  input wire [9:0] ct2_current,
  // general alarm conditions and other heater alarm
  input wire [3:0] gen_alarm_raw,
  input wire heater_short_alarm,
  // latch clear sources
  input wire programmable_function_key,
  input wire event_clear,
  input wire [2:0] setting_level,
  // alarm outputs
  output wire heater_burnout_alarm,
  output reg combined_heater_alarm_ff,
  output reg integrated_alarm_ff,
  output wire [3:0] gen_alarm,
  output reg [3:0] aux_out_ff
);

  // ==========================================================
  // helpers

  // clamp a written setting into its legal range
  function [9:0] clamp;
    input [15:0] val;
    input [9:0] lo;
    input [9:0] hi;
    begin
      if (val < {6'h00, lo}) begin
        clamp = lo;
      end else if (val > {6'h00, hi}) begin
        clamp = hi;
      end else begin
        clamp = val[9:0];
      end
    end
  endfunction

  // levels whose entry drops every held latch
  function is_setup_level;
    input [2:0] lvl;
    begin
      case (lvl)
        `HBA_LVL_INIT: is_setup_level = 1'b1;
        `HBA_LVL_COMM: is_setup_level = 1'b1;
        `HBA_LVL_ADV: is_setup_level = 1'b1;
        `HBA_LVL_CAL: is_setup_level = 1'b1;
        default: is_setup_level = 1'b0;
      endcase
    end
  endfunction

  // one aux output from its selection code
  function route;
    input [1:0] sel;
    input burn;
    input heat;
    input intg;
    begin
      case (sel)
        `HBA_SEL_BURN: route = burn;
        `HBA_SEL_HEAT: route = heat;
        `HBA_SEL_INTG: route = intg;
        default: route = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // settings registers
  reg [2:0] ctrl_ff; // enable, latch, fast period
  reg [9:0] hyst_ff; // shared hysteresis
  reg [9:0] thr1_ff; // channel 1 threshold
  reg [9:0] thr2_ff; // channel 2 threshold
  reg [7:0] asgn_ff; // two bits per aux output
  reg [7:0] gcfg_ff; // latch and standby per general alarm

  // monitor copies of the current readings
  reg [9:0] cur1_ff;
  reg [9:0] cur2_ff;

  // command pulses from the register port
  reg sw_clear_ff;
  reg restart_ff;

  // setting level history for entry detection
  reg [2:0] level_ff;
  reg latch_clear_ff;

  // heating on interval timer
  reg [31:0] on_cnt_ff;
  wire [31:0] skip_lim;
  wire eval;

  // channel results
  wire ch1_alarm;
  wire ch2_alarm;
  wire burn_raw;

  // decoded register strobes
  wire wr_ctrl;
  wire wr_hyst;
  wire wr_thr1;
  wire wr_thr2;
  wire wr_asgn;
  wire wr_cmd;
  wire wr_gcfg;

  // read mux
  reg [15:0] nxt_rdata;

  // routed aux outputs
  reg [3:0] nxt_aux;

  assign wr_ctrl = reg_wr & (reg_addr == `HBA_OFF_CTRL);
  assign wr_hyst = reg_wr & (reg_addr == `HBA_OFF_HYST);
  assign wr_thr1 = reg_wr & (reg_addr == `HBA_OFF_THR1);
  assign wr_thr2 = reg_wr & (reg_addr == `HBA_OFF_THR2);
  assign wr_asgn = reg_wr & (reg_addr == `HBA_OFF_ASGN);
  assign wr_cmd = reg_wr & (reg_addr == `HBA_OFF_CMD);
  assign wr_gcfg = reg_wr & (reg_addr == `HBA_OFF_GCFG);

  // ==========================================================
  // writable settings
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= `HBA_CTRL_RST; // see R9
      hyst_ff <= `HBA_HYST_RST; // see R11
      thr1_ff <= `HBA_THR_RST; // see R12
      thr2_ff <= `HBA_THR_RST; // see R12
      asgn_ff <= `HBA_ASGN_RST; // see R7
      gcfg_ff <= `HBA_GCFG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[2:0]; // see R10
      end
      // out-of-range values are pulled to the nearest limit
      if (wr_hyst) begin
        hyst_ff <= clamp(reg_wdata, `HBA_HYST_MIN,
                         `HBA_SET_MAX); // see R11
      end
      if (wr_thr1) begin
        thr1_ff <= clamp(reg_wdata, 10'h000,
                         `HBA_SET_MAX); // see R12
      end
      if (wr_thr2) begin
        thr2_ff <= clamp(reg_wdata, 10'h000,
                         `HBA_SET_MAX); // see R12
      end
      if (wr_asgn) begin
        asgn_ff <= reg_wdata[7:0]; // see R7
      end
      if (wr_gcfg) begin
        gcfg_ff <= reg_wdata[7:0];
      end
    end
  end

  // ==========================================================
  // command register: self-clearing one-cycle pulses
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sw_clear_ff <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      sw_clear_ff <= wr_cmd & reg_wdata[`HBA_CMD_CLEAR];
      restart_ff <= wr_cmd & reg_wdata[`HBA_CMD_RESTART];
    end
  end

  // ==========================================================
  // current monitors, saturated at the top of the range
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cur1_ff <= 10'h000;
      cur2_ff <= 10'h000;
    end else begin
      cur1_ff <= clamp({6'h00, ct1_current}, 10'h000,
                       `HBA_CUR_MAX); // see R13
      cur2_ff <= clamp({6'h00, ct2_current}, 10'h000,
                       `HBA_CUR_MAX); // see R13
    end
  end

  // ==========================================================
  // latch clear: function key, event input, software command,
  // or entry into a setup level; reset covers the power cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ff <= `HBA_LVL_OPER;
      latch_clear_ff <= 1'b0;
    end else begin
      level_ff <= setting_level;
      latch_clear_ff <= programmable_function_key | event_clear |
                        sw_clear_ff | // see R2
                        ((setting_level != level_ff) &
                         is_setup_level(setting_level)); // see R3
    end
  end

  // ==========================================================
  // heating on timer; only the heating output is watched, a
  // cooling output never reaches this block
  assign skip_lim = ctrl_ff[`HBA_CTRL_FAST] ? SKIP_SHORT_CYC :
                    SKIP_LONG_CYC; // see R6

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      on_cnt_ff <= 32'h00000000;
    end else if (!heat_out) begin
      on_cnt_ff <= 32'h00000000; // see R5
    end else if (on_cnt_ff <= skip_lim) begin
      // stops one past the limit, so it never wraps
      on_cnt_ff <= on_cnt_ff + 32'h00000001;
    end
  end

  // judged only once the on time is longer than the skip time;
  // between pulses the last verdict stands
  assign eval = heat_out & (on_cnt_ff > skip_lim); // see R6

  // ==========================================================
  // per-channel comparison
  hba_ch_detect u_ch1 (
    .clk(clk),
    .reset(reset),
    .enable(ctrl_ff[`HBA_CTRL_EN]),
    .eval(eval),
    .current(cur1_ff),
    .thr(thr1_ff),
    .hyst(hyst_ff),
    .alarm_ff(ch1_alarm)
  );

  hba_ch_detect u_ch2 (
    .clk(clk),
    .reset(reset),
    .enable(ctrl_ff[`HBA_CTRL_EN]),
    .eval(eval),
    .current(cur2_ff),
    .thr(thr2_ff),
    .hyst(hyst_ff),
    .alarm_ff(ch2_alarm)
  );

  // either channel raises the burnout condition
  assign burn_raw = ch1_alarm | ch2_alarm; // see R4

  // ==========================================================
  // burnout alarm qualifier: latch only, no standby
  hba_alarm_latch u_burn (
    .clk(clk),
    .reset(reset),
    .raw(burn_raw),
    .latch_en(ctrl_ff[`HBA_CTRL_LATCH]),
    .standby_en(1'b0),
    .restart(restart_ff),
    .clear(latch_clear_ff),
    .alarm_ff(heater_burnout_alarm)
  );

  // ==========================================================
  // four general alarms, each with its own latch and standby,
  // kept apart from the burnout alarm
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_gen
      hba_alarm_latch u_gen (
        .clk(clk),
        .reset(reset),
        .raw(gen_alarm_raw[gi]),
        .latch_en(gcfg_ff[gi]), // see R1
        .standby_en(gcfg_ff[gi+4]), // see R16
        .restart(restart_ff), // see R16
        .clear(latch_clear_ff), // see R2
        .alarm_ff(gen_alarm[gi])
      );
    end
  endgenerate

  // ==========================================================
  // combined heater alarm and integrated alarm
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      combined_heater_alarm_ff <= 1'b0;
      integrated_alarm_ff <= 1'b0;
    end else begin
      combined_heater_alarm_ff <= heater_burnout_alarm |
                                  heater_short_alarm;
      integrated_alarm_ff <= (|gen_alarm) | heater_burnout_alarm |
                             heater_short_alarm; // see R8
    end
  end

  // ==========================================================
  // aux output routing; the alarms only drive aux outputs and
  // have no path back to the heating output
  integer ai;
  always @* begin
    nxt_aux = 4'h0;
    for (ai = 0; ai < 4; ai = ai + 1) begin
      nxt_aux[ai] = route(asgn_ff[2*ai +: 2], heater_burnout_alarm,
                          combined_heater_alarm_ff,
                          integrated_alarm_ff); // see R7
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      aux_out_ff <= 4'h0;
    end else begin
      aux_out_ff <= nxt_aux; // see R14
    end
  end

  // ==========================================================
  // read path: data valid only in the cycle after the strobe,
  // zero otherwise and for unmapped offsets
  always @* begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `HBA_OFF_CTRL: nxt_rdata = {13'h0, ctrl_ff};
        `HBA_OFF_HYST: nxt_rdata = {6'h00, hyst_ff};
        `HBA_OFF_THR1: nxt_rdata = {6'h00, thr1_ff};
        `HBA_OFF_THR2: nxt_rdata = {6'h00, thr2_ff};
        `HBA_OFF_CUR1: nxt_rdata = {6'h00, cur1_ff}; // see R13
        `HBA_OFF_CUR2: nxt_rdata = {6'h00, cur2_ff}; // see R13
        `HBA_OFF_ASGN: nxt_rdata = {8'h00, asgn_ff};
        `HBA_OFF_STAT: nxt_rdata = {6'h00, eval, ch2_alarm,
                                    ch1_alarm, gen_alarm,
                                    integrated_alarm_ff,
                                    combined_heater_alarm_ff,
                                    heater_burnout_alarm};
        `HBA_OFF_GCFG: nxt_rdata = {8'h00, gcfg_ff};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_ff <= 16'h0000;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule

/* File: test/hba_top_props.sv */
// assertion checker for the heater burnout alarm block
`timescale 1ns/1ps
`include "hba_regs.vh"
module hba_top_props #(
  parameter [31:0] SKIP_LONG_CYC = 32'h14,
  parameter [31:0] SKIP_SHORT_CYC = 32'h6
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_ff,
  // process side
  input wire heat_out,
  input wire [9:0] ct1_current,
  input wire programmable_function_key,
  input wire event_clear,
  input wire [2:0] setting_level,
  // alarm outputs
  input wire heater_burnout_alarm,
  input wire combined_heater_alarm_ff,
  input wire integrated_alarm_ff,
  input wire [3:0] gen_alarm,
  input wire [3:0] aux_out_ff
);
  // ==========================================================
  // shadow of settings and heating run lengths
  reg en_ff; // detection enable copy
  reg latch_ff; // latch setting copy
  reg a1_ff; // aux 1 routed to burnout
  reg [2:0] lvl_ff; // previous setting level
  reg [31:0] run_ff; // current heating on run
  reg [31:0] last_ff; // length of the last finished run
  // any event that may clear a latch; bus writes counted too, on purpose
  wire clr_src = programmable_function_key | event_clear | reg_wr |
    (setting_level != lvl_ff);
  wire hit = reg_wr && (reg_addr == `HBA_OFF_CTRL);
  // shadow registers follow bus writes and the heating drive
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      en_ff <= 1'b1;
      latch_ff <= 1'b0;
      a1_ff <= 1'b1;
      lvl_ff <= 3'h0;
      run_ff <= 32'h0;
      last_ff <= 32'h0;
    end else begin
      if (hit) begin
        en_ff <= reg_wdata[`HBA_CTRL_EN];
        latch_ff <= reg_wdata[`HBA_CTRL_LATCH];
      end
      if (reg_wr && (reg_addr == `HBA_OFF_ASGN)) begin
        a1_ff <= (reg_wdata[1:0] == `HBA_SEL_BURN);
      end
      lvl_ff <= setting_level;
      run_ff <= heat_out ? run_ff + 32'h1 : 32'h0;
      if (!heat_out && (run_ff != 32'h0)) begin
        last_ff <= run_ff;
      end
    end
  end
  // monitor value saturates at the top of the range
  function [9:0] cmax(input [9:0] c);
    cmax = (c > `HBA_CUR_MAX) ? `HBA_CUR_MAX : c;
  endfunction
  // ==========================================================
  // sequences and properties
  sequence burn_rise;
    $rose(heater_burnout_alarm);
  endsequence
  sequence quiet_hold;
    (!clr_src)[*6] ##0 (latch_ff && heater_burnout_alarm);
  endsequence
  AST_SKIP_SHORT: assert property (@(posedge clk) disable iff (reset)
    burn_rise |-> (run_ff > SKIP_SHORT_CYC) || (last_ff > SKIP_SHORT_CYC))
    else $error("burnout rose without a long heating run");
  AST_COMBINED: assert property (@(posedge clk) disable iff (reset)
    burn_rise |=> combined_heater_alarm_ff && integrated_alarm_ff)
    else $error("burnout not carried to combined alarms");
  AST_INTEGRATED: assert property (@(posedge clk) disable iff (reset)
    (gen_alarm != 4'h0)[*2] |-> integrated_alarm_ff)
    else $error("integrated alarm misses a general alarm");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (reset)
    quiet_hold |=> heater_burnout_alarm)
    else $error("latched burnout dropped without a clear");
  AST_ENABLE_OFF: assert property (@(posedge clk) disable iff (reset)
    (!en_ff && !latch_ff)[*3] |-> !heater_burnout_alarm)
    else $error("burnout alarm while detection is off");
  AST_CUR_READ: assert property (@(posedge clk) disable iff (reset)
    reg_rd && (reg_addr == `HBA_OFF_CUR1) && $stable(ct1_current) |=>
    reg_rdata_ff == {6'h00, cmax($past(ct1_current, 2))})
    else $error("current monitor read wrong");
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (reset)
    !reg_rd |=> reg_rdata_ff == 16'h0000)
    else $error("read data not idle");
  AST_AUX_ROUTE: assert property (@(posedge clk) disable iff (reset)
    a1_ff[*3] |-> aux_out_ff[0] == $past(heater_burnout_alarm))
    else $error("aux 1 does not follow burnout");
endmodule
bind hba_top hba_top_props #(.SKIP_LONG_CYC(SKIP_LONG_CYC),
  .SKIP_SHORT_CYC(SKIP_SHORT_CYC)) u_props (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .heat_out(heat_out),
  .ct1_current(ct1_current),
  .programmable_function_key(programmable_function_key),
  .event_clear(event_clear), .setting_level(setting_level),
  .heater_burnout_alarm(heater_burnout_alarm),
  .combined_heater_alarm_ff(combined_heater_alarm_ff),
  .integrated_alarm_ff(integrated_alarm_ff), .gen_alarm(gen_alarm),
  .aux_out_ff(aux_out_ff));

/* File: test/hba_ct_model.sv */
// current transformer model: heater current seen on two channels
`timescale 1ns/1ps
module hba_ct_model (
  // heating drive as seen by the heater
  input wire heat_out,
  // current each heater draws when powered, 0.1 A steps
  input wire [9:0] load1,
  input wire [9:0] load2,
  // transformer readings
  output wire [9:0] ct1_current,
  output wire [9:0] ct2_current
);
  // heater supply is live from time zero, so current follows the drive
  // and no leakage flows while the drive is off
  assign ct1_current = heat_out ? load1 : 10'h000;
  assign ct2_current = heat_out ? load2 : 10'h000;
endmodule

/* File: test/testbench.sv */
// self-checking bench for the heater burnout alarm block
`timescale 1ns/1ps
`include "hba_regs.vh"
module testbench;
  // shortened skip limits keep the run brief
  localparam [31:0] LIM = 32'h14;
  localparam [31:0] LIMF = 32'h6;
  // ==========================================================
  // signals
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [15:0] reg_rdata_ff;
  reg heat_out = 1'b0;
  reg [9:0] load1 = 10'h000;
  reg [9:0] load2 = 10'h000;
  wire [9:0] ct1_current;
  wire [9:0] ct2_current;
  reg [3:0] gen_alarm_raw = 4'h0;
  reg heater_short_alarm = 1'b0;
  reg programmable_function_key = 1'b0;
  reg event_clear = 1'b0;
  reg [2:0] setting_level = 3'h0;
  wire heater_burnout_alarm;
  wire combined_heater_alarm_ff;
  wire integrated_alarm_ff;
  wire [3:0] gen_alarm;
  wire [3:0] aux_out_ff;
  logic [15:0] exp_q[$]; // expected read data, oldest first
  logic [15:0] msk_q[$]; // bits that matter per read
  integer n_errors = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i;
  reg pend = 1'b0;
  // ==========================================================
  // design and heater model
  hba_top #(.SKIP_LONG_CYC(LIM), .SKIP_SHORT_CYC(LIMF)) uut (.clk(clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .heat_out(heat_out), .ct1_current(ct1_current),
    .ct2_current(ct2_current), .gen_alarm_raw(gen_alarm_raw),
    .heater_short_alarm(heater_short_alarm),
    .programmable_function_key(programmable_function_key),
    .event_clear(event_clear), .setting_level(setting_level),
    .heater_burnout_alarm(heater_burnout_alarm),
    .combined_heater_alarm_ff(combined_heater_alarm_ff),
    .integrated_alarm_ff(integrated_alarm_ff), .gen_alarm(gen_alarm),
    .aux_out_ff(aux_out_ff));
  hba_ct_model u_ct (.heat_out(heat_out), .load1(load1), .load2(load2),
    .ct1_current(ct1_current), .ct2_current(ct2_current));
  always #2 clk = ~clk;
  // ==========================================================
  // tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read: the expectation is noted when the strobe goes out
  task rd(input [7:0] a, input [15:0] m, input [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // heating on for n edges, then a settle gap
  task pulse(input integer n);
    @(posedge clk);
    heat_out <= 1'b1;
    idle(n);
    heat_out <= 1'b0;
    idle(8);
  endtask
  // ==========================================================
  // read data watcher: one cycle after each strobe
  always @(posedge clk) begin
    if (pend) begin
      check(reg_rdata_ff & msk_q.pop_front(), exp_q.pop_front());
    end
    pend = reg_rd;
  end
  // hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h43c16c23));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(`HBA_OFF_CTRL, 16'h0007, 16'h0001);
    rd(`HBA_OFF_HYST, 16'h03ff, 16'h0001);
    rd(`HBA_OFF_THR1, 16'h03ff, 16'h0000);
    rd(`HBA_OFF_THR2, 16'h03ff, 16'h0000);
    rd(`HBA_OFF_ASGN, 16'h00ff, 16'h0001);
    rd(8'h0f, 16'hffff, 16'h0000);
    wr(`HBA_OFF_HYST, 16'h0000);
    rd(`HBA_OFF_HYST, 16'h03ff, 16'h0001);
    wr(`HBA_OFF_THR1, 16'h03ff);
    rd(`HBA_OFF_THR1, 16'h03ff, 16'h01f4);
    // channel 1 below threshold, short and long heating runs
    wr(`HBA_OFF_THR1, 16'h0032);
    wr(`HBA_OFF_HYST, 16'h0014);
    load1 <= 10'($urandom_range(49, 0));
    load2 <= 10'($urandom_range(550, 0));
    pulse(LIM + 1);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0000);
    pulse(LIM + 2);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0001);
    check({15'h0, aux_out_ff[0]}, 16'h0001);
    // recovery inside the hysteresis band keeps the alarm
    load1 <= 10'h03c;
    pulse(LIM + 4);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0001);
    load1 <= 10'h046;
    pulse(LIM + 4);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0000);
    // monitors read while heating, one above the range
    @(posedge clk);
    heat_out <= 1'b1;
    load2 <= 10'h258;
    idle(3);
    rd(`HBA_OFF_CUR2, 16'hffff, 16'h0226);
    rd(`HBA_OFF_CUR1, 16'hffff, 16'h0046);
    heat_out <= 1'b0;
    idle(8);
    // channel 2 on its own threshold, normal then fast period
    wr(`HBA_OFF_THR2, 16'h0064);
    load2 <= 10'h032;
    pulse(LIM + 2);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0001);
    load2 <= 10'h0c8;
    pulse(LIM + 2);
    wr(`HBA_OFF_CTRL, 16'h0005);
    load2 <= 10'h032;
    pulse(LIMF + 1);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0000);
    pulse(LIMF + 2);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0001);
    load2 <= 10'h0c8;
    pulse(LIMF + 2);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0000);
    // latched alarm against every clear source except reset
    wr(`HBA_OFF_CTRL, 16'h0003);
    for (i = 0; i < 7; i = i + 1) begin
      load2 <= 10'h032;
      pulse(LIM + 2);
      load2 <= 10'h0c8;
      pulse(LIM + 2);
      rd(`HBA_OFF_STAT, 16'h0001, 16'h0001);
      if (i == 6) wr(`HBA_OFF_CMD, 16'h0001);
      else begin
        @(posedge clk);
        if (i == 0) programmable_function_key <= 1'b1;
        else if (i == 1) event_clear <= 1'b1;
        else setting_level <= i[2:0];
        @(posedge clk);
        programmable_function_key <= 1'b0;
        event_clear <= 1'b0;
      end
      idle(6);
      rd(`HBA_OFF_STAT, 16'h0001, 16'h0000);
      setting_level <= 3'h0;
    end
    // detection switched off
    wr(`HBA_OFF_CTRL, 16'h0000);
    load2 <= 10'h032;
    pulse(LIM + 2);
    rd(`HBA_OFF_STAT, 16'h0001, 16'h0000);
    // general alarms and routing of combined and integrated alarms
    wr(`HBA_OFF_ASGN, 16'h0039);
    gen_alarm_raw <= 4'h5;
    idle(4);
    rd(`HBA_OFF_STAT, 16'h0079, 16'h0028);
    check({12'h0, aux_out_ff}, 16'h0004);
    gen_alarm_raw <= 4'h0;
    heater_short_alarm <= 1'b1;
    idle(4);
    check({12'h0, aux_out_ff}, 16'h0006);
    heater_short_alarm <= 1'b0;
    idle(4);
    give_verdict;
  end
endmodule
